// ==== hw/sfu_unit.sv ====
// single precision float unit: add, subtract, multiply, divide with timing and abort
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sfu_unit
	import sfu_pkg::*;
#(
	parameter logic [15:0] MUL_BASE_CYC = SFU_MUL_CYC,
	parameter logic [15:0] DIV_BASE_CYC = SFU_DIV_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire sfu_req_t req,
	input wire logic bus_request_line,
	output logic busy,
	output logic done,
	output logic result_write,
	output logic abort,
	output logic instr_boundary,
	output sfu_res_t res
);

	typedef enum {
		SFU_IDLE,
		SFU_ALIGN,
		SFU_ARITH,
		SFU_DIVW,
		SFU_NORM,
		SFU_ROUND,
		SFU_WAIT
	} sfu_state_t;

	sfu_state_t state;
	sfu_op_t op;
	logic sa, sb, ws, div_zero, ok;
	logic signed [10:0] ea, eb, we;
	logic [23:0] ma, mb;
	logic [49:0] wa, wb, wm;
	logic [15:0] rem_cyc;
	logic [15:0] next_add;
	logic [7:0] nshift;
	logic [47:0] prod;
	logic div_start, div_done, div_rem_nz;
	logic [26:0] div_q;
	logic [24:0] rnd;
	logic signed [10:0] next_exp;
	logic [31:0] next_value;
	logic go_abort;

	// ----------------------------------------------------------------
	// control and handshake
	// ----------------------------------------------------------------
	assign busy = state != SFU_IDLE;
	assign instr_boundary = state == SFU_IDLE;
	// only a request early in the instruction abandons it
	assign go_abort = busy && bus_request_line && rem_cyc > SFU_ABORT_CYC;
	assign prod = ma * mb;
	assign div_start = state == SFU_ARITH && op == float_divide_op && !div_zero;

	sfu_frac_div u_div (
		.mclk(mclk),
		.rst(rst),
		.start(div_start),
		.dividend(ma),
		.divisor(mb),
		.done(div_done),
		.quotient(div_q),
		.rem_nz(div_rem_nz)
	);

	// extra time owed by this cycle's shifts
	always_comb
	begin
		next_add = 16'h0000;
		if (state == SFU_ALIGN && ea != eb && nshift != 8'h00)
			next_add = SFU_ALIGN_CYC;
		if (state == SFU_NORM && !wm[49] && wm != 50'h0 && !wm[48])
			next_add = SFU_NORM_CYC;
	end

	// execution timer: counts down the time the instruction still needs
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rem_cyc <= 16'h0000;
		else if (state == SFU_IDLE && start)
		begin
			case (req.op)
				float_add_op: rem_cyc <= SFU_ADD_CYC;
				float_subtract_op: rem_cyc <= SFU_SUB_CYC;
				float_multiply_op: rem_cyc <= MUL_BASE_CYC;
				float_divide_op: rem_cyc <= DIV_BASE_CYC;
				default: rem_cyc <= SFU_ADD_CYC;
			endcase
		end
		else if (busy)
			rem_cyc <= rem_cyc + next_add - {15'h0000, rem_cyc != 16'h0000};
	end

	// ----------------------------------------------------------------
	// rounding and packing
	// ----------------------------------------------------------------
	// sticky bits below the fraction push the magnitude up
	always_comb
	begin
		rnd = {1'b0, wm[48:25]} + {24'h000000, wm[24:0] != 25'h0};
		next_exp = we;
		if (rnd[24])
			next_exp = we + 11'sh001;
		ok = next_exp > 11'sh000 && next_exp <= SFU_EXP_MAX;
		next_value = {ws, next_exp[7:0], rnd[24] ? rnd[23:1] : rnd[22:0]};
		if (wm == 50'h0)
		begin
			ok = 1'b1;
			next_value = SFU_CLEAN_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// datapath sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= SFU_IDLE;
			op <= float_add_op;
			sa <= 1'b0;
			sb <= 1'b0;
			ws <= 1'b0;
			ea <= 11'sh000;
			eb <= 11'sh000;
			we <= 11'sh000;
			ma <= 24'h000000;
			mb <= 24'h000000;
			wa <= 50'h0;
			wb <= 50'h0;
			wm <= 50'h0;
			nshift <= 8'h00;
			div_zero <= 1'b0;
			done <= 1'b0;
			result_write <= 1'b0;
			abort <= 1'b0;
			res <= '0;
		end
		else
		begin
			done <= 1'b0;
			result_write <= 1'b0;
			abort <= 1'b0;
			if (go_abort)
			begin
				abort <= 1'b1;
				state <= SFU_IDLE;
			end
			else
			begin
				case (state)
					SFU_IDLE:
						if (start)
						begin
							// a zero exponent makes the whole operand zero
							op <= req.op;
							sa <= req.acc[SFU_SIGN_BIT];
							sb <= req.src[SFU_SIGN_BIT] ^ (req.op == float_subtract_op);
							ma <= req.acc[30:23] == 8'h00 ? 24'h000000 : {1'b1, req.acc[22:0]};
							mb <= req.src[30:23] == 8'h00 ? 24'h000000 : {1'b1, req.src[22:0]};
							wa <= req.acc[30:23] == 8'h00 ? 50'h0 : {2'b01, req.acc[22:0], 25'h0};
							wb <= req.src[30:23] == 8'h00 ? 50'h0 : {2'b01, req.src[22:0], 25'h0};
							// zero operand takes the other exponent, so no alignment
							ea <= {3'b000, req.acc[30:23] == 8'h00 ? req.src[30:23] : req.acc[30:23]};
							eb <= {3'b000, req.src[30:23] == 8'h00 ? req.acc[30:23] : req.src[30:23]};
							div_zero <= req.src[30:23] == 8'h00 && req.op == float_divide_op;
							nshift <= 8'h00;
							state <= SFU_ALIGN;
						end
					SFU_ALIGN:
						if (op == float_multiply_op || op == float_divide_op || ea == eb)
							state <= SFU_ARITH;
						else
						begin
							// sticky lsb keeps lost bits visible to rounding
							nshift <= nshift + 8'h01;
							if (ea < eb)
							begin
								wa <= {1'b0, wa[49:2], wa[1] | wa[0]};
								ea <= ea + 11'sh001;
							end
							else
							begin
								wb <= {1'b0, wb[49:2], wb[1] | wb[0]};
								eb <= eb + 11'sh001;
							end
						end
					SFU_ARITH:
					begin
						we <= ea;
						state <= SFU_NORM;
						case (op)
							float_multiply_op:
							begin
								ws <= sa ^ sb;
								// product of two fractions keeps its binary point at the top of wm
								wm <= {1'b0, prod, 1'b0};
								we <= ea + eb - SFU_EXP_BIAS;
							end
							float_divide_op:
							begin
								ws <= sa ^ sb;
								wm <= 50'h0;
								if (div_zero)
									state <= SFU_WAIT;
								else if (ma != 24'h000000)
									state <= SFU_DIVW;
							end
							default:
								if (sa == sb)
								begin
									ws <= sa;
									wm <= wa + wb;
								end
								else if (wa >= wb)
								begin
									ws <= sa;
									wm <= wa - wb;
								end
								else
								begin
									ws <= sb;
									wm <= wb - wa;
								end
						endcase
					end
					SFU_DIVW:
						if (div_done)
						begin
							// quotient integer bit sits above the point; normalize shifts it back
							wm <= {div_q, 22'h0, div_rem_nz};
							we <= ea - eb + SFU_EXP_BIAS;
							state <= SFU_NORM;
						end
					SFU_NORM:
						if (wm[49])
						begin
							wm <= {1'b0, wm[49:2], wm[1] | wm[0]};
							we <= we + 11'sh001;
						end
						else if (wm != 50'h0 && !wm[48])
						begin
							wm <= {wm[48:0], 1'b0};
							we <= we - 11'sh001;
						end
						else
							state <= SFU_ROUND;
					SFU_ROUND:
					begin
						res.value <= ok ? next_value : SFU_CLEAN_ZERO;
						res.n <= (ok && next_value[SFU_SIGN_BIT]) || (!ok && next_exp <= 11'sh000);
						res.z <= ok && next_value == SFU_CLEAN_ZERO;
						res.v <= !ok;
						res.c <= 1'b0;
						state <= SFU_WAIT;
					end
					SFU_WAIT:
					begin
						if (div_zero)
						begin
							res.n <= 1'b0;
							res.z <= 1'b0;
							res.v <= 1'b0;
							res.c <= 1'b1;
						end
						// hold the answer until the instruction time is spent
						if (rem_cyc == 16'h0000)
						begin
							done <= 1'b1;
							result_write <= !div_zero && !res.v;
							state <= SFU_IDLE;
						end
					end
					default:
						state <= SFU_IDLE;
				endcase
			end
		end
	end

endmodule : sfu_unit
`default_nettype wire

// ==== hw/sfu_pkg.sv ====
// package: formats, operation codes, carriers and timing of the single precision float unit
package sfu_pkg;

	// ----------------------------------------------------------------
	// number format
	// ----------------------------------------------------------------
	localparam int SFU_WORD_W = 32;
	localparam int SFU_EXP_W = 8;
	localparam int SFU_FRAC_W = 24;
	localparam int SFU_STORED_W = 23;
	localparam int SFU_SIGN_BIT = 31;
	localparam int SFU_EXP_LSB = 23;
	localparam int SFU_XEXP_W = 11;
	localparam int SFU_WORK_W = 50;
	localparam int SFU_PROD_W = 48;
	localparam int SFU_QUOT_W = 27;
	localparam int SFU_GUARD_W = 25;
	localparam int SFU_QUOT_POS = 22;
	localparam logic signed [10:0] SFU_EXP_BIAS = 11'sh080;
	localparam logic signed [10:0] SFU_EXP_MAX = 11'sh0ff;
	localparam logic [31:0] SFU_CLEAN_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing, figures in ns, counts in mclk cycles
	// ----------------------------------------------------------------
	localparam int SFU_CLK_NS = 5;
	localparam int SFU_ADD_NS = 18780;
	localparam int SFU_SUB_NS = 19080;
	localparam int SFU_MUL_NS = 29000;
	localparam int SFU_DIV_NS = 46270;
	localparam int SFU_ALIGN_NS = 300;
	localparam int SFU_NORM_NS = 340;
	localparam int SFU_ABORT_NS = 8000;
	localparam int SFU_TIMER_W = 16;
	localparam logic [15:0] SFU_ADD_CYC = 16'((SFU_ADD_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_SUB_CYC = 16'((SFU_SUB_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_MUL_CYC = 16'((SFU_MUL_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_DIV_CYC = 16'((SFU_DIV_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_ALIGN_CYC = 16'((SFU_ALIGN_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_NORM_CYC = 16'((SFU_NORM_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);
	localparam logic [15:0] SFU_ABORT_CYC = 16'((SFU_ABORT_NS + SFU_CLK_NS - 1) / SFU_CLK_NS);

	// ----------------------------------------------------------------
	// operations and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		float_add_op,
		float_subtract_op,
		float_multiply_op,
		float_divide_op
	} sfu_op_t;

	typedef struct packed {
		sfu_op_t op;
		logic [31:0] acc;
		logic [31:0] src;
	} sfu_req_t;

	typedef struct packed {
		logic [31:0] value;
		logic n;
		logic z;
		logic v;
		logic c;
	} sfu_res_t;

endpackage : sfu_pkg

// ==== hw/sfu_frac_div.sv ====
// restoring fraction divider for the single precision float unit
`timescale 1ns/1ps
`default_nettype none
module sfu_frac_div
	import sfu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [23:0] dividend,
	input wire logic [23:0] divisor,
	output logic done,
	output logic [26:0] quotient,
	output logic rem_nz
);

	// ----------------------------------------------------------------
	// one quotient bit per cycle
	// ----------------------------------------------------------------
	logic [24:0] rem;
	logic [23:0] dsor;
	logic [4:0] cnt;
	logic run;
	logic ge;
	logic [24:0] trial;

	// remainder stays below twice the divisor, so the shift never overflows
	always_comb
	begin
		ge = rem >= {1'b0, dsor};
		trial = ge ? rem - {1'b0, dsor} : rem;
	end

	// step counter and remainder
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rem <= 25'h0000000;
			dsor <= 24'h000000;
			cnt <= 5'h00;
			run <= 1'b0;
			quotient <= 27'h0000000;
			done <= 1'b0;
			rem_nz <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				rem <= {1'b0, dividend};
				dsor <= divisor;
				cnt <= 5'(SFU_QUOT_W);
				run <= 1'b1;
			end
			else if (run)
			begin
				rem <= {trial[23:0], 1'b0};
				quotient <= {quotient[25:0], ge};
				cnt <= cnt - 5'h01;
				if (cnt == 5'h01)
				begin
					run <= 1'b0;
					done <= 1'b1;
					rem_nz <= trial != 25'h0000000;
				end
			end
		end
	end

endmodule : sfu_frac_div
`default_nettype wire

// ==== testbench/sfu_unit_chk.sv ====
// checker: port-level timing and result relations of the float unit
`timescale 1ns/1ps
`default_nettype none
module sfu_unit_chk
	import sfu_pkg::*;
#(
	parameter logic [15:0] MUL_BASE_CYC = SFU_MUL_CYC,
	parameter logic [15:0] DIV_BASE_CYC = SFU_DIV_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire sfu_req_t req,
	input wire logic bus_request_line,
	input wire logic busy,
	input wire logic done,
	input wire logic result_write,
	input wire logic abort,
	input wire logic instr_boundary,
	input wire sfu_res_t res
);
	// ----------------------------------------------------------------
	// helper: cycles since the take and base time of the taken op
	// ----------------------------------------------------------------
	logic [15:0] cyc;
	logic [15:0] base;
	// saturates so a long idle spell cannot wrap into a false match
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			cyc <= 16'h0;
		else if (start && !busy)
			cyc <= 16'h0;
		else if (cyc != 16'hffff)
			cyc <= cyc + 16'h1;
	// base count latched at the take
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			base <= 16'h0;
		else if (start && !busy)
			base <= req.op == float_add_op ? SFU_ADD_CYC :
				req.op == float_subtract_op ? SFU_SUB_CYC :
				req.op == float_multiply_op ? MUL_BASE_CYC : DIV_BASE_CYC;

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_take;
		start && !busy;
	endsequence
	sequence s_end;
		done || abort;
	endsequence

	a_take_busy: assert property (s_take |=> busy)
		else $error("busy missing after take");
	a_end_idle: assert property (s_end |-> !busy && instr_boundary)
		else $error("unit busy at end");
	a_boundary_idle: assert property (instr_boundary == !busy)
		else $error("boundary not idle");
	a_write_done: assert property (result_write |-> done)
		else $error("write without done");
	a_single_end: assert property (s_end |=> !done && !abort)
		else $error("end pulse too long");
	a_zero_clean: assert property (done && res.z |-> res.value == SFU_CLEAN_ZERO)
		else $error("zero not clean");
	a_divzero_skip: assert property (done && res.c |-> !result_write && !res.v)
		else $error("zero divisor written");
	a_overflow_skip: assert property (done && res.v |-> !result_write)
		else $error("range fault written");
	a_abort_hold: assert property (abort |-> $stable(res) && !done)
		else $error("abort changed result");
	a_min_time: assert property (done |-> cyc >= base)
		else $error("done too early");
	a_late_request: assert property (busy && bus_request_line && cyc + 16'd1598 >= base
		|=> !abort)
		else $error("late request aborted");
	a_early_request: assert property (busy && bus_request_line && cyc + 16'd1610 < base
		|=> abort)
		else $error("early request not aborted");
endmodule : sfu_unit_chk

bind sfu_unit sfu_unit_chk #(.MUL_BASE_CYC(MUL_BASE_CYC), .DIV_BASE_CYC(DIV_BASE_CYC)) u_chk (
	.mclk(mclk),
	.rst(rst),
	.start(start),
	.req(req),
	.bus_request_line(bus_request_line),
	.busy(busy),
	.done(done),
	.result_write(result_write),
	.abort(abort),
	.instr_boundary(instr_boundary),
	.res(res)
);
`default_nettype wire

// ==== testbench/sfu_host_model.sv ====
// host side model: floating accumulator commit and restart tracking
`timescale 1ns/1ps
`default_nettype none
module sfu_host_model
	import sfu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic done,
	input wire logic result_write,
	input wire logic abort,
	input wire sfu_res_t res,
	output logic [31:0] fac,
	output logic restart
);
	// only results free of range faults reach the accumulator
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			fac <= 32'h0;
		else if (result_write)
			fac <= res.value;
	// abort keeps the instruction pending until it completes
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			restart <= 1'b0;
		else if (abort)
			restart <= 1'b1;
		else if (done)
			restart <= 1'b0;
endmodule : sfu_host_model
`default_nettype wire

// ==== testbench/test_sfu_unit.sv ====
// bench for the single precision float unit
`timescale 1ns/1ps
`default_nettype none
module test_sfu_unit
	import sfu_pkg::*;
;
	logic mclk, rst, start, bus_request_line, busy, done, result_write, abort, instr_boundary;
	logic restart, hung;
	sfu_req_t req;
	sfu_res_t res;
	logic [31:0] fac, m_fac, a, b;
	logic [35:0] last;
	int bad_count, comparisons, n, i, extra;

	sfu_unit #(.MUL_BASE_CYC(16'h190), .DIV_BASE_CYC(16'h190)) u_dut (.mclk(mclk), .rst(rst),
		.start(start), .req(req), .bus_request_line(bus_request_line), .busy(busy),
		.done(done), .result_write(result_write), .abort(abort),
		.instr_boundary(instr_boundary), .res(res));
	sfu_host_model u_host (.mclk(mclk), .rst(rst), .done(done), .result_write(result_write),
		.abort(abort), .res(res), .fac(fac), .restart(restart));

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// reference multiply: excess-128 exponents, round away from zero
	function automatic logic [35:0] ref_mul(input logic [31:0] x, input logic [31:0] y);
		longint p;
		int e;
		logic [23:0] m;
		if (x[30:23] == 8'h0 || y[30:23] == 8'h0)
			return {32'h0, 4'h4};
		p = longint'({1'b1, x[22:0]}) * longint'({1'b1, y[22:0]});
		e = int'(x[30:23]) + int'(y[30:23]) - 128;
		if (!p[47])
		begin
			p = p <<< 1;
			e = e - 1;
		end
		m = p[47:24] + 24'(p[23:0] != 0);
		if (m == 24'h0)
		begin
			m = 24'h80_0000;
			e = e + 1;
		end
		return {x[31] ^ y[31], 8'(e), m[22:0], x[31] ^ y[31], 3'h0};
	endfunction : ref_mul

	// one instruction; br_at above zero raises a bus request that many cycles after the take
	task automatic run(input sfu_op_t op, input logic [31:0] x, input logic [31:0] y,
		input int br_at, input logic [35:0] ev, input logic ew, input logic ea);
		logic [15:0] base;
		base = op == float_add_op ? SFU_ADD_CYC : op == float_subtract_op ? SFU_SUB_CYC : 16'h190;
		if (hung)
			return;
		@(negedge mclk);
		start = 1'b1;
		req = '{op, x, y};
		@(negedge mclk);
		start = 1'b0;
		for (n = 1; n < 20000; n++)
		begin
			bus_request_line = br_at > 0 && n >= br_at;
			@(posedge mclk);
			#1;
			if (done === 1'b1 || abort === 1'b1)
				break;
			@(negedge mclk);
		end
		if (n == 20000)
		begin
			// a hang counts once and skips the rest; the verdict still runs at the end
			bad_count++;
			hung = 1'b1;
			return;
		end
		chk("abort", abort, ea);
		chk("write", result_write, ew);
		chk("result", res, ea ? last : ev);
		if (!ea)
			chk("time", n >= base + extra, 1'b1);
		if (ew)
			m_fac = ev[35:4];
		if (!ea)
			last = ev;
		@(negedge mclk);
		bus_request_line = 1'b0;
		@(posedge mclk);
		#1;
		chk("fac", fac, m_fac);
		chk("restart", restart, ea);
		$display("test done: op %0d", op);
	endtask : run

	initial
	begin
		rst = 1'b1;
		start = 1'b0;
		bus_request_line = 1'b0;
		req = '0;
		bad_count = 0;
		comparisons = 0;
		m_fac = 32'h0;
		last = 36'h0;
		hung = 1'b0;
		extra = 0;
		void'($urandom(78021));
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		chk("idle", {busy, done, abort, instr_boundary}, 4'h1);
		run(float_add_op, 32'h4080_0000, 32'h4080_0000, 0, {32'h4100_0000, 4'h0}, 1, 0);
		run(float_subtract_op, 32'h4080_0000, 32'h4000_0000, 0, {32'h4000_0000, 4'h0}, 1, 0);
		// exponents three apart: two alignment shifts beyond the first cost extra time
		extra = 2 * SFU_ALIGN_CYC;
		run(float_add_op, 32'h4100_0000, 32'h3f80_0000, 0, {32'h4110_0000, 4'h0}, 1, 0);
		extra = 0;
		for (i = 0; i < 4; i++)
		begin
			a = {1'($urandom), 8'h70 + 8'($urandom % 32), 23'($urandom)};
			b = {1'($urandom), 8'h70 + 8'($urandom % 32), 23'($urandom)};
			run(float_multiply_op, a, b, 0, ref_mul(a, b), 1, 0);
		end
		run(float_multiply_op, 32'h4080_0000, 32'h807f_ffff, 0, {32'h0, 4'h4}, 1, 0);
		run(float_multiply_op, 32'h7f80_0000, 32'h7f80_0000, 0, {32'h0, 4'h2}, 0, 0);
		run(float_divide_op, 32'h4080_0000, 32'h4080_0000, 0, {32'h4080_0000, 4'h0}, 1, 0);
		run(float_divide_op, 32'h4080_0000, 32'h0, 0, {32'h4080_0000, 4'h1}, 0, 0);
		run(float_add_op, 32'h4080_0000, 32'h4080_0000, 1, 36'h0, 0, 1);
		run(float_add_op, 32'h4080_0000, 32'h4080_0000, 0, {32'h4100_0000, 4'h0}, 1, 0);
		run(float_add_op, 32'h4080_0000, 32'h4080_0000, 3000, {32'h4100_0000, 4'h0}, 1, 0);
		complete_run();
	end
endmodule : test_sfu_unit
`default_nettype wire
